// File: logic/dac_loader_map.svh
`ifndef DAC_LOADER_MAP_SVH
`define DAC_LOADER_MAP_SVH
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DL_OP_WRITE      2'h1
`define DL_ADDR_LSB      0
`define DL_OP_LSB        2
`define DL_SEL_LOW       2'h0
`define DL_SEL_MID       2'h1
`define DL_SEL_HIGH      2'h2
`define DL_IDLE_LEVEL    1'b1
`define DL_WORD_RESET    16'h0000
`define DL_NIB_RESET     4'h0
`define DL_BYTE_RESET    8'h00
`endif

// File: logic/dac_loader_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------
package dac_loader_pkg;
    typedef enum logic [0:0] {
        BYTE_FIRST  = 1'b0,
        BYTE_SECOND = 1'b1
    } byte_phase_e;
    typedef logic [3:0] nibble_t;
endpackage
`default_nettype wire

// File: logic/host_bus_to_dac_loader.sv
// Functional notes
// - Bus buffer drives only when converter addressed
// - First byte held, second forms 16-bit word
// - Converter bits right-justified in wide word
// - Chip-select and write only during load
// - Idle converter inputs held at defined level
// - Strobe fall latches address and op nibble
// - Low two bits address, high two op
// - Only write op enables converter decoder
// - Strobe rise loads decoded converter only
// - Two address lines pick low/mid/high nibble
// - Selector routes low or high bus nibble
// - Low byte fills low then middle nibble
// - Selector isolates converter unless addressed
// - Address and strobe gated while not addressed
`include "dac_loader_map.svh"
`timescale 1ns/1ps
`default_nettype none
module host_bus_to_dac_loader #(
    parameter int DAC_BITS = 12,  // Converter resolution
    parameter int NUM_DACS = 4    // Converters behind the expander
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // Byte-pair scheme
    input  wire logic                pair_addr_hit,
    input  wire logic                pair_wr,
    input  wire logic [7:0]          pair_data,
    output logic                     pair_buf_en,
    output logic [7:0]               pair_buf_out,
    output logic [15:0]              pair_word,
    output logic [DAC_BITS-1:0]      pair_dac_data,
    output logic                     pair_dac_load,
    // Expander scheme
    input  wire logic                expander_strobe,
    input  wire logic [3:0]          expander_nibble,
    output logic [NUM_DACS-1:0]      exp_dac_load,
    output logic [3:0]               exp_dac_data,
    output logic [1:0]               exp_reg_addr,
    // Nibble selector scheme
    input  wire logic                sel_addr_hit,
    input  wire logic                sel_wr,
    input  wire logic [1:0]          sel_addr,
    input  wire logic [7:0]          sel_data,
    output logic [3:0]               sel_dac_nibble,
    output logic [1:0]               sel_dac_addr,
    output logic                     sel_dac_wr,
    output logic [DAC_BITS-1:0]      sel_dac_word
);
    // The selector image has a full low and middle nibble and a high
    // nibble of one to four bits, so the word is 9 to 12 bits wide.
    // Only two latched address bits pick a converter, so at most four.
    initial begin
        if (DAC_BITS < 9 || DAC_BITS > 12 || NUM_DACS < 1 || NUM_DACS > 4)
            $error("host_bus_to_dac_loader: unsupported parameters");
    end

    // ------------------------------------------------------------------
    // Byte-pair assembly
    // ------------------------------------------------------------------
    dac_loader_pkg::byte_phase_e phase_r;       // Which byte comes next
    logic [7:0]                  hold_r;        // First byte holding latch
    logic [15:0]                 word_r;        // Assembled word
    logic                        load_r;        // One-cycle update pulse
    wire logic                   pair_take;     // Write to converter

    // Write taken only while the converter address is decoded
    // gated chip-select
    assign pair_take   = pair_addr_hit & pair_wr;
    assign pair_buf_en = pair_addr_hit;
    assign pair_buf_out = pair_addr_hit ? pair_data
                                        : {8{`DL_IDLE_LEVEL}};
    assign pair_word     = word_r;
    assign pair_dac_data = word_r[DAC_BITS-1:0];
    assign pair_dac_load = load_r;

    // Phase, holding latch and word; the word only moves as a whole
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_r <= dac_loader_pkg::BYTE_FIRST;
            hold_r  <= `DL_BYTE_RESET;
            word_r  <= `DL_WORD_RESET;
            load_r  <= 1'b0;
        end else begin
            load_r <= 1'b0;
            if (pair_take) begin
                if (phase_r == dac_loader_pkg::BYTE_FIRST) begin
                    hold_r  <= pair_data;
                    phase_r <= dac_loader_pkg::BYTE_SECOND;
                end else begin
                    word_r  <= {pair_data, hold_r};
                    load_r  <= 1'b1;
                    phase_r <= dac_loader_pkg::BYTE_FIRST;
                end
            end
        end
    end

    // Buffer enable follows the decoded address and nothing else
    chk_buf_enable: assert property (
        @(posedge ref_clk) disable iff (rst)
        pair_buf_en == pair_addr_hit)
        else $error("buffer enable not tied to address");

    // Idle converter inputs sit at the pull-up level
    chk_idle_level: assert property (
        @(posedge ref_clk) disable iff (rst)
        !pair_addr_hit |-> pair_buf_out == 8'hFF)
        else $error("idle bus not pulled up");

    // Second byte lands high, held first byte lands low
    chk_pair_word: assert property (
        @(posedge ref_clk) disable iff (rst)
        pair_take && phase_r == dac_loader_pkg::BYTE_SECOND |=>
        pair_word == {$past(pair_data), $past(hold_r)})
        else $error("second byte did not form word");

    // A first byte must never move the applied word
    chk_first_keeps: assert property (
        @(posedge ref_clk) disable iff (rst)
        pair_take && phase_r == dac_loader_pkg::BYTE_FIRST |=>
        pair_word == $past(pair_word) && !pair_dac_load)
        else $error("first byte changed the word");

    // Update pulse only after the second byte
    chk_second_only: assert property (
        @(posedge ref_clk) disable iff (rst)
        pair_dac_load |-> $past(phase_r) == dac_loader_pkg::BYTE_SECOND)
        else $error("converter updated on first byte");

    // Update pulse only after a gated write
    chk_load_gated: assert property (
        @(posedge ref_clk) disable iff (rst)
        pair_dac_load |-> $past(pair_take))
        else $error("converter load without gated write");

    // Update pulse lasts one clock
    chk_load_single: assert property (
        @(posedge ref_clk) disable iff (rst)
        pair_dac_load |=> !pair_dac_load)
        else $error("converter load pulse too long");

    // ------------------------------------------------------------------
    // Expander port scheme
    // ------------------------------------------------------------------
    // The strobe is sampled, so its edges are seen one clock late; the
    // host must hold each nibble across its strobe edge for a cycle.
    logic                        strobe_d_r;    // Strobe last cycle
    logic [3:0]                  cmd_r;         // Latched addr and op
    logic [3:0]                  exp_data_r;    // Data nibble out
    logic [NUM_DACS-1:0]         exp_load_r;    // Per-converter load
    wire logic                   strobe_fall;
    wire logic                   strobe_rise;
    wire logic [1:0]             cmd_op;
    wire logic [1:0]             cmd_addr;
    wire logic                   decoder_enable_high;
    wire logic                   decoder_enable_low_b;
    wire logic [NUM_DACS-1:0]    dac_pick;

    // One-hot decode of a converter index
    function automatic logic [NUM_DACS-1:0] onehot(input logic [1:0] a,
                                                   input logic en);
        logic [NUM_DACS-1:0] v;
        v = '0;
        if (en && int'(a) < NUM_DACS)
            v[a] = 1'b1;
        return v;
    endfunction

    assign strobe_fall = strobe_d_r & ~expander_strobe;
    assign strobe_rise = ~strobe_d_r & expander_strobe;
    assign cmd_addr = cmd_r[`DL_ADDR_LSB +: 2];
    assign cmd_op   = cmd_r[`DL_OP_LSB +: 2];
    assign decoder_enable_high  = (cmd_op == `DL_OP_WRITE);
    assign decoder_enable_low_b = ~decoder_enable_high;
    assign dac_pick = onehot(cmd_addr,
                             decoder_enable_high & ~decoder_enable_low_b);
    assign exp_dac_load = exp_load_r;
    assign exp_dac_data = exp_data_r;
    assign exp_reg_addr = cmd_addr;

    // Edge detection, command latch and load pulses
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strobe_d_r <= 1'b1;
            cmd_r      <= `DL_NIB_RESET;
            exp_data_r <= `DL_NIB_RESET;
            exp_load_r <= '0;
        end else begin
            strobe_d_r <= expander_strobe;
            exp_load_r <= '0;
            if (strobe_fall)
                cmd_r <= expander_nibble;
            if (strobe_rise) begin
                exp_data_r <= expander_nibble;
                exp_load_r <= dac_pick;
            end
        end
    end

    // Non-write op codes leave every converter unselected; the host's
    // read and logic ops are meant for its own port expander.
    chk_op_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        cmd_op != `DL_OP_WRITE |-> dac_pick == '0)
        else $error("non-write op selected converter");

    // Rising strobe loads the decoded converter, at most one
    chk_rise_load: assert property (
        @(posedge ref_clk) disable iff (rst)
        strobe_rise |=>
        exp_dac_load == $past(dac_pick) && $onehot0(exp_dac_load))
        else $error("wrong converter loaded");

    // No load pulse without a rising strobe
    chk_no_stray: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(strobe_rise) |-> exp_dac_load == '0)
        else $error("converter loaded without strobe rise");

    // Falling strobe latches the whole command nibble
    chk_cmd_latch: assert property (
        @(posedge ref_clk) disable iff (rst)
        strobe_fall |=> cmd_r == $past(expander_nibble))
        else $error("command nibble not latched");

    // Register address comes from the two low bits
    chk_field_split: assert property (
        @(posedge ref_clk) disable iff (rst)
        strobe_fall |=> exp_reg_addr == $past(expander_nibble[1:0]))
        else $error("register address not from low bits");

    // ------------------------------------------------------------------
    // Nibble selector scheme
    // ------------------------------------------------------------------
    logic [DAC_BITS-1:0]         sel_word_r;    // Converter input image
    wire logic                   sel_take;
    wire logic [3:0]             sel_nib;

    // Middle address picks the upper half of the byte
    // nibble selector
    assign sel_nib = (sel_addr == `DL_SEL_MID) ? sel_data[7:4]
                                               : sel_data[3:0];
    assign sel_dac_nibble = sel_addr_hit ? sel_nib : `DL_NIB_RESET;
    assign sel_dac_addr = sel_addr_hit ? sel_addr : 2'h3;
    assign sel_take     = sel_addr_hit & sel_wr;
    assign sel_dac_wr   = sel_take;
    assign sel_dac_word = sel_word_r;

    // Image of the three converter nibble registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_word_r <= '0;
        end else if (sel_take) begin
            // low byte to low and middle
            case (sel_addr)
                `DL_SEL_LOW:  sel_word_r[3:0] <= sel_nib;
                `DL_SEL_MID:  sel_word_r[7:4] <= sel_nib;
                `DL_SEL_HIGH: sel_word_r[DAC_BITS-1:8] <=
                                  sel_nib[DAC_BITS-9:0];
                // Unused fourth address: image left alone
                default:      sel_word_r <= sel_word_r;
            endcase
        end
    end

    // Bus activity must not reach the converter while unaddressed
    chk_sel_isolate: assert property (
        @(posedge ref_clk) disable iff (rst)
        !sel_addr_hit |-> !sel_dac_wr && sel_dac_nibble == 4'h0)
        else $error("selector not isolating");

    // Gated address parks on the unused code while idle
    chk_sel_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        !sel_addr_hit |-> sel_dac_addr == 2'h3)
        else $error("converter address not gated");

    // Middle write takes the upper half of the low byte
    chk_mid_nibble: assert property (
        @(posedge ref_clk) disable iff (rst)
        sel_take && sel_addr == `DL_SEL_MID |=>
        sel_word_r[7:4] == $past(sel_data[7:4]))
        else $error("middle nibble not from bits 7:4");

    // Middle address routes bits 7:4 to the converter
    chk_mid_route: assert property (
        @(posedge ref_clk) disable iff (rst)
        sel_addr_hit && sel_addr == `DL_SEL_MID |->
        sel_dac_nibble == sel_data[7:4])
        else $error("middle address not routed from bits 7:4");

    // Low and high addresses route bits 3:0 to the converter
    chk_low_route: assert property (
        @(posedge ref_clk) disable iff (rst)
        sel_addr_hit && sel_addr != `DL_SEL_MID |->
        sel_dac_nibble == sel_data[3:0])
        else $error("low or high address not from bits 3:0");
endmodule // host_bus_to_dac_loader
`default_nettype wire

// File: tb/exp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Expander port host model
// ----------------------------------------------------------------------
module exp_host_model (
    input  wire logic       ref_clk,
    output logic            expander_strobe,
    output logic [3:0]      expander_nibble
);
    // Idle: strobe high, nibble parked
    initial begin
        expander_strobe = 1'b1;
        expander_nibble = 4'h0;
    end
    task automatic send(input logic [3:0] cmd, input logic [3:0] dat);
        @(negedge ref_clk) expander_nibble = cmd;
        @(negedge ref_clk) expander_strobe = 1'b0;
        repeat (2) @(negedge ref_clk);
        expander_nibble = dat;
        @(negedge ref_clk) expander_strobe = 1'b1;
        repeat (2) @(negedge ref_clk);
        // Hold over: inverse shown so a stale capture cannot match
        expander_nibble = ~dat;
    endtask
endmodule // exp_host_model
`default_nettype wire

// File: tb/host_bus_to_dac_loader_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module host_bus_to_dac_loader_test;
    logic        ref_clk = 1'b0;   // 25 MHz
    logic        rst = 1'b1;       // Sync reset
    logic        pair_addr_hit, pair_wr, pair_buf_en, pair_dac_load;
    logic [7:0]  pair_data, pair_buf_out;
    logic [15:0] pair_word;
    logic [11:0] pair_dac_data, sel_dac_word;
    logic        expander_strobe, sel_addr_hit, sel_wr, sel_dac_wr;
    logic [3:0]  expander_nibble, exp_dac_load, exp_dac_data;
    logic [3:0]  sel_dac_nibble;
    logic [1:0]  exp_reg_addr, sel_addr, sel_dac_addr;
    logic [7:0]  sel_data;
    int          n_fail = 0;       // Mismatches
    int          num_checks = 0;   // Comparisons
    // Clock
    always #20 ref_clk = ~ref_clk;
    host_bus_to_dac_loader #(.DAC_BITS(12), .NUM_DACS(4)) dut (
        .ref_clk(ref_clk), .rst(rst),
        .pair_addr_hit(pair_addr_hit), .pair_wr(pair_wr),
        .pair_data(pair_data), .pair_buf_en(pair_buf_en),
        .pair_buf_out(pair_buf_out), .pair_word(pair_word),
        .pair_dac_data(pair_dac_data), .pair_dac_load(pair_dac_load),
        .expander_strobe(expander_strobe),
        .expander_nibble(expander_nibble),
        .exp_dac_load(exp_dac_load), .exp_dac_data(exp_dac_data),
        .exp_reg_addr(exp_reg_addr),
        .sel_addr_hit(sel_addr_hit), .sel_wr(sel_wr),
        .sel_addr(sel_addr), .sel_data(sel_data),
        .sel_dac_nibble(sel_dac_nibble), .sel_dac_addr(sel_dac_addr),
        .sel_dac_wr(sel_dac_wr), .sel_dac_word(sel_dac_word));
    exp_host_model host (.ref_clk(ref_clk),
        .expander_strobe(expander_strobe),
        .expander_nibble(expander_nibble));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Byte pair: buffer gating, assembly, single update
    task automatic t_pair;
        logic [15:0] loads;
        loads = 16'h0000;
        @(negedge ref_clk);
        chk(pair_buf_en, 16'h0000);
        chk(pair_buf_out, 16'h00FF);
        pair_addr_hit = 1'b1;
        pair_wr = 1'b1;
        pair_data = 8'h34;
        #1 chk(pair_buf_en, 16'h0001);
        chk(pair_buf_out, 16'h0034);
        @(negedge ref_clk) loads = loads + pair_dac_load;
        pair_data = 8'hA2;
        @(negedge ref_clk) loads = loads + pair_dac_load;
        pair_wr = 1'b0;
        pair_addr_hit = 1'b0;
        repeat (3) @(negedge ref_clk) loads = loads + pair_dac_load;
        chk(loads, 16'h0001);
        chk(pair_word, 16'hA234);
        chk(pair_dac_data, 16'h0234);
        // Write strobe with no address hit must not load
        pair_wr = 1'b1;
        pair_data = 8'h55;
        @(negedge ref_clk) pair_wr = 1'b0;
        repeat (3) @(negedge ref_clk) loads = loads + pair_dac_load;
        chk(loads, 16'h0001);
        chk(pair_word, 16'hA234);
    endtask
    // Expander: every op code and address
    task automatic t_exp;
        logic [3:0] seen, d;
        for (int op = 0; op < 4; op++) begin
            for (int a = 0; a < 4; a++) begin
                seen = 4'h0;
                d = {2'(a), 2'(op)} ^ 4'h6;
                fork
                    host.send({2'(op), 2'(a)}, d);
                    repeat (9) @(negedge ref_clk) seen = seen | exp_dac_load;
                join
                chk(seen, (op == 1) ? 16'(1 << a) : 16'h0000);
                chk(exp_reg_addr, 16'(a));
                if (op == 1) chk(exp_dac_data, d);
            end
        end
    endtask
    // One selector write, then idle gating
    task automatic wr_sel(input logic [1:0] ad, input logic [7:0] dt,
                          input logic [3:0] nib);
        @(negedge ref_clk);
        sel_addr_hit = 1'b1;
        sel_addr = ad;
        sel_data = dt;
        sel_wr = 1'b1;
        #1 chk(sel_dac_nibble, nib);
        chk(sel_dac_addr, ad);
        chk(sel_dac_wr, 16'h0001);
        @(negedge ref_clk);
        sel_wr = 1'b0;
        sel_addr_hit = 1'b0;
        sel_data = ~dt;
        #1 chk(sel_dac_nibble, 16'h0000);
        chk(sel_dac_addr, 16'h0003);
    endtask
    task automatic t_sel;
        wr_sel(2'h0, 8'hA5, 4'h5);
        wr_sel(2'h1, 8'hA5, 4'hA);
        wr_sel(2'h2, 8'h3C, 4'hC);
        wr_sel(2'h3, 8'hFF, 4'hF);
        @(negedge ref_clk) chk(sel_dac_word, 16'h0CA5);
        sel_wr = 1'b1;
        #1 chk(sel_dac_wr, 16'h0000);
        @(negedge ref_clk) sel_wr = 1'b0;
        @(negedge ref_clk) chk(sel_dac_word, 16'h0CA5);
    endtask
    // Main sequence
    initial begin
        pair_addr_hit = 1'b0;
        pair_wr = 1'b0;
        pair_data = 8'h00;
        sel_addr_hit = 1'b0;
        sel_wr = 1'b0;
        sel_addr = 2'h0;
        sel_data = 8'h00;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        t_pair();
        t_exp();
        t_sel();
        give_verdict();
    end
endmodule // host_bus_to_dac_loader_test
`default_nettype wire
